// ===== pkg/osd_defines.vh
// Offsets, field positions, reset values and timing constants of the output driver bank
`ifndef OSD_DEFINES_VH
`define OSD_DEFINES_VH

`define OSD_ADDR_W 7
`define OSD_OFS_HP_DRV_CTRL 7'h26
`define OSD_OFS_RSVD_A 7'h27
`define OSD_OFS_OUT_STAGE_CTRL 7'h28
`define OSD_OFS_DAC_ROUTE_CTRL 7'h29
`define OSD_OFS_DRV_PON_TIMING 7'h2a

`define OSD_HP_RCOM_MSB 5
`define OSD_HP_RCOM_LSB 3
`define OSD_HP_SCP_EN 2
`define OSD_HP_SCP_MODE 1
`define OSD_OS_CM_MSB 7
`define OSD_OS_CM_LSB 6
`define OSD_OS_RSVD_MSB 5
`define OSD_OS_RSVD_LSB 2
`define OSD_OS_SS_MSB 1
`define OSD_OS_SS_LSB 0
`define OSD_RT_L_MSB 7
`define OSD_RT_L_LSB 6
`define OSD_RT_R_MSB 5
`define OSD_RT_R_LSB 4
`define OSD_RT_RSVD_MSB 3
`define OSD_RT_RSVD_LSB 2
`define OSD_RT_LINK_MSB 1
`define OSD_RT_LINK_LSB 0
`define OSD_PT_DLY_MSB 7
`define OSD_PT_DLY_LSB 4
`define OSD_PT_STEP_MSB 3
`define OSD_PT_STEP_LSB 2
`define OSD_PT_WEAK_CM 1
`define OSD_PT_RSVD0 0

`define OSD_RST_FIELD1 1'h0
`define OSD_RST_FIELD2 2'h0
`define OSD_RST_FIELD3 3'h0
`define OSD_RST_FIELD4 4'h0
`define OSD_RST_BYTE 8'h00

`define OSD_SS_ONE_FS 2'h0
`define OSD_SS_TWO_FS 2'h1
`define OSD_SS_OFF 2'h2
`define OSD_LINK_L_FOLLOWS_R 2'h1
`define OSD_LINK_R_FOLLOWS_L 2'h2

`define OSD_CLK_MHZ 250
`define OSD_T_D1_US 10
`define OSD_T_D2_US 100
`define OSD_T_D3_MS 1
`define OSD_T_D4_MS 10
`define OSD_T_D5_MS 50
`define OSD_T_D7_MS 200
`define OSD_T_D8_MS 400
`define OSD_T_D9_MS 800
`define OSD_T_D10_S 2
`define OSD_T_D11_S 4
`define OSD_T_S1_MS 1
`define OSD_T_S2_MS 2
`define OSD_T_S3_MS 4
`define OSD_CYC_PER_MS (`OSD_CLK_MHZ * 1000)
`define OSD_CYC_PER_S (`OSD_CLK_MHZ * 1000000)
`define OSD_MS_PER_S 1000
`define OSD_RAMP_STEPS 3'h7

`endif

// ===== rtl/osd_pwr_seq.v
// Driver power-on sequencer: delay wait, then stepped ramp
`timescale 1ns/10ps
`default_nettype none
`include "osd_defines.vh"

module osd_pwr_seq #(
    parameter [31:0] D3 = 32'd250000,
    parameter [31:0] D4 = 32'd2500000,
    parameter [31:0] D5 = 32'd12500000,
    parameter [31:0] D7 = 32'd50000000,
    parameter [31:0] D8 = 32'd100000000,
    parameter [31:0] D9 = 32'd200000000,
    parameter [31:0] D10 = 32'd500000000,
    parameter [31:0] D11 = 32'd1000000000,
    parameter [31:0] S1 = 32'd250000,
    parameter [31:0] S2 = 32'd500000,
    parameter [31:0] S3 = 32'd1000000
) (
    input wire clock,
    input wire reset,
    input wire pwr_req,
    input wire [3:0] dly_code,
    input wire [1:0] step_code,
    output reg [2:0] ramp_level_r,
    output reg ready_r
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_RAMP = 2'h2;
    localparam [1:0] ST_ON = 2'h3;
    localparam [31:0] D1 = `OSD_T_D1_US * `OSD_CLK_MHZ;
    localparam [31:0] D2 = `OSD_T_D2_US * `OSD_CLK_MHZ;

    reg [1:0] state_r;
    reg [31:0] cnt_r;
    reg [31:0] dly_cyc;
    reg [31:0] step_cyc;

    // Reserved codes fall back to no delay
    always @*
    begin
        case (dly_code)
            4'h1: dly_cyc = D1;
            4'h2: dly_cyc = D2;
            4'h3: dly_cyc = D3;
            4'h4: dly_cyc = D4;
            4'h5: dly_cyc = D5;
            4'h6: dly_cyc = D5;
            4'h7: dly_cyc = D7;
            4'h8: dly_cyc = D8;
            4'h9: dly_cyc = D9;
            4'ha: dly_cyc = D10;
            4'hb: dly_cyc = D11;
            default: dly_cyc = 32'h0;
        endcase
        case (step_code)
            2'h1: step_cyc = S1;
            2'h2: step_cyc = S2;
            2'h3: step_cyc = S3;
            default: step_cyc = 32'h0;
        endcase
    end

    always @(posedge clock)
    begin
        if (reset || !pwr_req)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 32'h0;
            ramp_level_r <= 3'h0;
            ready_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    state_r <= ST_DELAY;
                    cnt_r <= dly_cyc;
                end
                ST_DELAY:
                begin
                    if (cnt_r == 32'h0)
                    begin
                        state_r <= ST_RAMP;
                        cnt_r <= step_cyc;
                    end
                    else
                        cnt_r <= cnt_r - 32'h1;
                end
                ST_RAMP:
                begin
                    if (cnt_r == 32'h0)
                    begin
                        ramp_level_r <= ramp_level_r + 3'h1;
                        cnt_r <= step_cyc;
                        if (ramp_level_r == `OSD_RAMP_STEPS - 3'h1)
                        begin
                            state_r <= ST_ON;
                            ready_r <= 1'b1;
                        end
                    end
                    else
                        cnt_r <= cnt_r - 32'h1;
                end
                ST_ON:
                    state_r <= ST_ON;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // osd_pwr_seq

`default_nettype wire

// ===== rtl/osd_regs.v
// Output driver control register bank with volume linking and soft-stepping
//
// What this block does
// - Three-bit field picks how the right common driver is configured, codes 000-100.
// - One bit enables short-circuit protection on all high-power drivers.
// - Protection mode: 0 limits load current, 1 powers driver down on short.
// - Two-bit common-mode level, ascending, 00 lowest to 11 highest.
// - Soft-stepping: one step per sample, per two samples, or immediate.
// - Left DAC routing picks path one, three or two; 11 reserved.
// - Right DAC routing picks path one, three or two; 11 reserved.
// - Volume linking: 01 left follows right, 10 right follows left, else independent.
// - Four-bit power-on delay code maps 0000-1011 to 0 up to 4 s.
// - Two-bit ramp step time is 0, 1, 2 or 4 ms.
// - Weak common-mode source: 0 supply divider, 1 band-gap.
// - Digital volume is seven-bit attenuation plus mute; linking copies the code.
`timescale 1ns/10ps
`default_nettype none
`include "osd_defines.vh"

module osd_regs #(
    parameter [31:0] CYC_PER_MS = `OSD_CYC_PER_MS,
    parameter [31:0] DLY_1MS = `OSD_T_D3_MS * CYC_PER_MS,
    parameter [31:0] DLY_10MS = `OSD_T_D4_MS * CYC_PER_MS,
    parameter [31:0] DLY_50MS = `OSD_T_D5_MS * CYC_PER_MS,
    parameter [31:0] DLY_200MS = `OSD_T_D7_MS * CYC_PER_MS,
    parameter [31:0] DLY_400MS = `OSD_T_D8_MS * CYC_PER_MS,
    parameter [31:0] DLY_800MS = `OSD_T_D9_MS * CYC_PER_MS,
    parameter [31:0] DLY_2S = `OSD_T_D10_S * `OSD_MS_PER_S * CYC_PER_MS,
    parameter [31:0] DLY_4S = `OSD_T_D11_S * `OSD_MS_PER_S * CYC_PER_MS,
    parameter [31:0] STEP_1MS = `OSD_T_S1_MS * CYC_PER_MS,
    parameter [31:0] STEP_2MS = `OSD_T_S2_MS * CYC_PER_MS,
    parameter [31:0] STEP_4MS = `OSD_T_S3_MS * CYC_PER_MS
) (
    input wire CLOCK,
    input wire RESET,
    input wire [6:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    input wire SAMPLE_TICK,
    input wire [7:0] LEFT_VOL_REG,
    input wire [7:0] RIGHT_VOL_REG,
    input wire DRV_PWR_REQ,
    output reg [2:0] RIGHT_COMMON_DRIVER_CFG,
    output reg SC_PROT_EN,
    output reg SC_PROT_PDN_MODE,
    output reg [1:0] COMMON_MODE_LEVEL_SEL,
    output reg [1:0] SOFT_STEP_SEL,
    output reg [1:0] LEFT_DAC_ROUTE,
    output reg [1:0] RIGHT_DAC_ROUTE,
    output reg WEAK_CM_BANDGAP,
    output reg [6:0] LEFT_VOL_APPLIED,
    output reg LEFT_MUTE,
    output reg [6:0] RIGHT_VOL_APPLIED,
    output reg RIGHT_MUTE,
    output wire [2:0] DRV_RAMP_LEVEL,
    output wire DRV_READY
);
    reg [2:0] rcom_r;
    reg scp_en_r;
    reg scp_mode_r;
    reg [1:0] cm_r;
    reg [3:0] os_rsvd_r;
    reg [1:0] ss_r;
    reg [1:0] route_l_r;
    reg [1:0] route_r_r;
    reg [1:0] rt_rsvd_r;
    reg [1:0] link_r;
    reg [3:0] dly_r;
    reg [1:0] step_r;
    reg weak_cm_r;
    reg pt_rsvd_r;
    reg half_r;
    reg [7:0] rdata_nxt;
    reg [7:0] vol_tgt_l;
    reg [7:0] vol_tgt_r;
    wire step_ok;

    wire wr_hp = REG_WR && (REG_ADDR == `OSD_OFS_HP_DRV_CTRL);
    wire wr_os = REG_WR && (REG_ADDR == `OSD_OFS_OUT_STAGE_CTRL);
    wire wr_rt = REG_WR && (REG_ADDR == `OSD_OFS_DAC_ROUTE_CTRL);
    wire wr_pt = REG_WR && (REG_ADDR == `OSD_OFS_DRV_PON_TIMING);

    // Bits 7-6 and 0 of driver control are read-only zero, so not stored
    always @(posedge CLOCK)
    begin
        if (RESET)
        begin
            rcom_r <= `OSD_RST_FIELD3;
            scp_en_r <= `OSD_RST_FIELD1;
            scp_mode_r <= `OSD_RST_FIELD1;
            cm_r <= `OSD_RST_FIELD2;
            os_rsvd_r <= `OSD_RST_FIELD4;
            ss_r <= `OSD_RST_FIELD2;
            route_l_r <= `OSD_RST_FIELD2;
            route_r_r <= `OSD_RST_FIELD2;
            rt_rsvd_r <= `OSD_RST_FIELD2;
            link_r <= `OSD_RST_FIELD2;
            dly_r <= `OSD_RST_FIELD4;
            step_r <= `OSD_RST_FIELD2;
            weak_cm_r <= `OSD_RST_FIELD1;
            pt_rsvd_r <= `OSD_RST_FIELD1;
        end
        else
        begin
            if (wr_hp)
            begin
                rcom_r <= REG_WDATA[`OSD_HP_RCOM_MSB:`OSD_HP_RCOM_LSB];
                scp_en_r <= REG_WDATA[`OSD_HP_SCP_EN];
                scp_mode_r <= REG_WDATA[`OSD_HP_SCP_MODE];
            end
            if (wr_os)
            begin
                cm_r <= REG_WDATA[`OSD_OS_CM_MSB:`OSD_OS_CM_LSB];
                os_rsvd_r <= REG_WDATA[`OSD_OS_RSVD_MSB:`OSD_OS_RSVD_LSB];
                ss_r <= REG_WDATA[`OSD_OS_SS_MSB:`OSD_OS_SS_LSB];
            end
            if (wr_rt)
            begin
                route_l_r <= REG_WDATA[`OSD_RT_L_MSB:`OSD_RT_L_LSB];
                route_r_r <= REG_WDATA[`OSD_RT_R_MSB:`OSD_RT_R_LSB];
                rt_rsvd_r <= REG_WDATA[`OSD_RT_RSVD_MSB:`OSD_RT_RSVD_LSB];
                link_r <= REG_WDATA[`OSD_RT_LINK_MSB:`OSD_RT_LINK_LSB];
            end
            if (wr_pt)
            begin
                dly_r <= REG_WDATA[`OSD_PT_DLY_MSB:`OSD_PT_DLY_LSB];
                step_r <= REG_WDATA[`OSD_PT_STEP_MSB:`OSD_PT_STEP_LSB];
                weak_cm_r <= REG_WDATA[`OSD_PT_WEAK_CM];
                pt_rsvd_r <= REG_WDATA[`OSD_PT_RSVD0];
            end
        end
    end

    // Reserved slot and unmapped addresses read zero; writes there are dropped
    always @*
    begin
        case (REG_ADDR)
            `OSD_OFS_HP_DRV_CTRL:
                rdata_nxt = {2'h0, rcom_r, scp_en_r, scp_mode_r, 1'b0};
            `OSD_OFS_RSVD_A:
                rdata_nxt = `OSD_RST_BYTE;
            `OSD_OFS_OUT_STAGE_CTRL:
                rdata_nxt = {cm_r, os_rsvd_r, ss_r};
            `OSD_OFS_DAC_ROUTE_CTRL:
                rdata_nxt = {route_l_r, route_r_r, rt_rsvd_r, link_r};
            `OSD_OFS_DRV_PON_TIMING:
                rdata_nxt = {dly_r, step_r, weak_cm_r, pt_rsvd_r};
            default:
                rdata_nxt = `OSD_RST_BYTE;
        endcase
    end

    always @(posedge CLOCK)
    begin
        if (RESET)
            REG_RDATA <= `OSD_RST_BYTE;
        else if (REG_RD)
            REG_RDATA <= rdata_nxt;
    end

    // Registered copies of the analog control fields
    always @(posedge CLOCK)
    begin
        if (RESET)
        begin
            RIGHT_COMMON_DRIVER_CFG <= `OSD_RST_FIELD3;
            SC_PROT_EN <= `OSD_RST_FIELD1;
            SC_PROT_PDN_MODE <= `OSD_RST_FIELD1;
            COMMON_MODE_LEVEL_SEL <= `OSD_RST_FIELD2;
            SOFT_STEP_SEL <= `OSD_RST_FIELD2;
            LEFT_DAC_ROUTE <= `OSD_RST_FIELD2;
            RIGHT_DAC_ROUTE <= `OSD_RST_FIELD2;
            WEAK_CM_BANDGAP <= `OSD_RST_FIELD1;
        end
        else
        begin
            RIGHT_COMMON_DRIVER_CFG <= rcom_r;
            SC_PROT_EN <= scp_en_r;
            // Mode only matters while protection is on
            SC_PROT_PDN_MODE <= scp_en_r & scp_mode_r;
            COMMON_MODE_LEVEL_SEL <= cm_r;
            SOFT_STEP_SEL <= ss_r;
            LEFT_DAC_ROUTE <= route_l_r;
            RIGHT_DAC_ROUTE <= route_r_r;
            WEAK_CM_BANDGAP <= weak_cm_r;
        end
    end

    // Linked channel takes the other's attenuation code and mute
    always @*
    begin
        vol_tgt_l = LEFT_VOL_REG;
        vol_tgt_r = RIGHT_VOL_REG;
        if (link_r == `OSD_LINK_L_FOLLOWS_R)
            vol_tgt_l = RIGHT_VOL_REG;
        else if (link_r == `OSD_LINK_R_FOLLOWS_L)
            vol_tgt_r = LEFT_VOL_REG;
    end

    // Every other sample tick, for the two-sample stepping rate
    always @(posedge CLOCK)
    begin
        if (RESET)
            half_r <= 1'b0;
        else if (SAMPLE_TICK)
            half_r <= ~half_r;
    end

    assign step_ok = SAMPLE_TICK && ((ss_r == `OSD_SS_ONE_FS) ||
                     ((ss_r == `OSD_SS_TWO_FS) && half_r));

    // Mute passes at once; attenuation walks one half-dB code per step
    always @(posedge CLOCK)
    begin
        if (RESET)
        begin
            LEFT_VOL_APPLIED <= 7'h00;
            RIGHT_VOL_APPLIED <= 7'h00;
            LEFT_MUTE <= 1'b1;
            RIGHT_MUTE <= 1'b1;
        end
        else
        begin
            LEFT_MUTE <= vol_tgt_l[7];
            RIGHT_MUTE <= vol_tgt_r[7];
            if (ss_r == `OSD_SS_OFF)
                LEFT_VOL_APPLIED <= vol_tgt_l[6:0];
            else if (step_ok && (LEFT_VOL_APPLIED < vol_tgt_l[6:0]))
                LEFT_VOL_APPLIED <= LEFT_VOL_APPLIED + 7'h01;
            else if (step_ok && (LEFT_VOL_APPLIED > vol_tgt_l[6:0]))
                LEFT_VOL_APPLIED <= LEFT_VOL_APPLIED - 7'h01;
            if (ss_r == `OSD_SS_OFF)
                RIGHT_VOL_APPLIED <= vol_tgt_r[6:0];
            else if (step_ok && (RIGHT_VOL_APPLIED < vol_tgt_r[6:0]))
                RIGHT_VOL_APPLIED <= RIGHT_VOL_APPLIED + 7'h01;
            else if (step_ok && (RIGHT_VOL_APPLIED > vol_tgt_r[6:0]))
                RIGHT_VOL_APPLIED <= RIGHT_VOL_APPLIED - 7'h01;
        end
    end

    // Long counts are parameters so simulation can shrink them
    osd_pwr_seq #(
        .D3(DLY_1MS),
        .D4(DLY_10MS),
        .D5(DLY_50MS),
        .D7(DLY_200MS),
        .D8(DLY_400MS),
        .D9(DLY_800MS),
        .D10(DLY_2S),
        .D11(DLY_4S),
        .S1(STEP_1MS),
        .S2(STEP_2MS),
        .S3(STEP_4MS)
    ) u_seq (
        .clock(CLOCK),
        .reset(RESET),
        .pwr_req(DRV_PWR_REQ),
        .dly_code(dly_r),
        .step_code(step_r),
        .ramp_level_r(DRV_RAMP_LEVEL),
        .ready_r(DRV_READY)
    );
endmodule // osd_regs

`default_nettype wire

// ===== verif/osd_regs_chk.sv
// Port-level assertions for the output driver control bank
`timescale 1ns/10ps
`default_nettype none
`include "osd_defines.vh"

module osd_regs_chk (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [6:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic DRV_PWR_REQ,
    input wire logic [2:0] RIGHT_COMMON_DRIVER_CFG,
    input wire logic SC_PROT_EN,
    input wire logic SC_PROT_PDN_MODE,
    input wire logic [1:0] COMMON_MODE_LEVEL_SEL,
    input wire logic [1:0] SOFT_STEP_SEL,
    input wire logic [1:0] LEFT_DAC_ROUTE,
    input wire logic [1:0] RIGHT_DAC_ROUTE,
    input wire logic WEAK_CM_BANDGAP,
    input wire logic [2:0] DRV_RAMP_LEVEL,
    input wire logic DRV_READY
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    wire logic wr_hp = REG_WR && REG_ADDR == `OSD_OFS_HP_DRV_CTRL;
    wire logic wr_os = REG_WR && REG_ADDR == `OSD_OFS_OUT_STAGE_CTRL;
    wire logic wr_rt = REG_WR && REG_ADDR == `OSD_OFS_DAC_ROUTE_CTRL;
    wire logic wr_pt = REG_WR && REG_ADDR == `OSD_OFS_DRV_PON_TIMING;
    // Field outputs packed so one stability check covers them all
    wire logic [13:0] flds = {RIGHT_COMMON_DRIVER_CFG, SC_PROT_EN, SC_PROT_PDN_MODE,
        COMMON_MODE_LEVEL_SEL, SOFT_STEP_SEL, LEFT_DAC_ROUTE, RIGHT_DAC_ROUTE, WEAK_CM_BANDGAP};

    rcom_prot_a: assert property (wr_hp |-> ##2
        flds[13:10] == $past(REG_WDATA[5:2], 2)) else $error("driver cfg wrong");
    pdn_mode_a: assert property (wr_hp |-> ##2
        SC_PROT_PDN_MODE == ($past(REG_WDATA[1], 2) & $past(REG_WDATA[2], 2)))
        else $error("prot mode wrong");
    mode_gate_a: assert property (SC_PROT_PDN_MODE |-> SC_PROT_EN)
        else $error("mode without enable");
    stage_field_a: assert property (wr_os |-> ##2
        flds[8:5] == {$past(REG_WDATA[7:6], 2), $past(REG_WDATA[1:0], 2)})
        else $error("stage field wrong");
    route_field_a: assert property (wr_rt |-> ##2
        flds[4:1] == $past(REG_WDATA[7:4], 2)) else $error("route field wrong");
    weak_cm_a: assert property (wr_pt |-> ##2
        WEAK_CM_BANDGAP == $past(REG_WDATA[1], 2)) else $error("weak cm wrong");
    hold_fields_a: assert property (!$past(REG_WR, 2) |-> $stable(flds))
        else $error("field moved without write");
    rsvd_read_a: assert property (REG_RD && REG_ADDR == `OSD_OFS_RSVD_A |=>
        REG_RDATA == 8'h00) else $error("reserved slot not zero");
    hp_rsvd_a: assert property (REG_RD && REG_ADDR == `OSD_OFS_HP_DRV_CTRL |=>
        (REG_RDATA & 8'hc1) == 8'h00) else $error("reserved bits not zero");
    ready_level_a: assert property (DRV_READY |-> DRV_RAMP_LEVEL == 3'h7)
        else $error("ready before full ramp");
    req_drop_a: assert property (!DRV_PWR_REQ |=>
        !DRV_READY && DRV_RAMP_LEVEL == 3'h0) else $error("ramp not cleared");
endmodule // osd_regs_chk

bind osd_regs osd_regs_chk i_chk (.CLOCK, .RESET, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
    .REG_RDATA, .DRV_PWR_REQ, .RIGHT_COMMON_DRIVER_CFG, .SC_PROT_EN, .SC_PROT_PDN_MODE,
    .COMMON_MODE_LEVEL_SEL, .SOFT_STEP_SEL, .LEFT_DAC_ROUTE, .RIGHT_DAC_ROUTE,
    .WEAK_CM_BANDGAP, .DRV_RAMP_LEVEL, .DRV_READY);
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the output driver control bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic CLOCK, RESET, REG_WR, REG_RD, SAMPLE_TICK, DRV_PWR_REQ, rd_pend;
    logic [6:0] REG_ADDR;
    logic [7:0] REG_WDATA, LEFT_VOL_REG, RIGHT_VOL_REG, d;
    wire logic [7:0] REG_RDATA;
    wire logic [6:0] LEFT_VOL_APPLIED, RIGHT_VOL_APPLIED;
    wire logic [2:0] RIGHT_COMMON_DRIVER_CFG, DRV_RAMP_LEVEL;
    wire logic [1:0] COMMON_MODE_LEVEL_SEL, SOFT_STEP_SEL, LEFT_DAC_ROUTE, RIGHT_DAC_ROUTE;
    wire logic SC_PROT_EN, SC_PROT_PDN_MODE, WEAK_CM_BANDGAP, LEFT_MUTE, RIGHT_MUTE, DRV_READY;
    logic [7:0] exp_q[$];
    logic [7:0] sh[0:127];
    logic [31:0] rnd = 32'hdfa88b7e;
    logic [6:0] rlist[7] = '{7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h00};
    int dtab[12] = '{0, 2500, 25000, 1, 10, 50, 50, 200, 400, 800, 2000, 4000};
    int stab[4] = '{0, 1, 2, 4};
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    // One cycle per millisecond keeps the longest power-up codes affordable
    osd_regs #(.CYC_PER_MS(1))
        i_dut (.CLOCK, .RESET, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
        .SAMPLE_TICK, .LEFT_VOL_REG, .RIGHT_VOL_REG, .DRV_PWR_REQ, .RIGHT_COMMON_DRIVER_CFG,
        .SC_PROT_EN, .SC_PROT_PDN_MODE, .COMMON_MODE_LEVEL_SEL, .SOFT_STEP_SEL,
        .LEFT_DAC_ROUTE, .RIGHT_DAC_ROUTE, .WEAK_CM_BANDGAP, .LEFT_VOL_APPLIED, .LEFT_MUTE,
        .RIGHT_VOL_APPLIED, .RIGHT_MUTE, .DRV_RAMP_LEVEL, .DRV_READY);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Software never writes reserved codes or reserved bits
    function automatic logic [7:0] legal(input logic [6:0] a, input logic [7:0] v);
        case (a)
            7'h26: return v & (v[5] && v[4:3] != 2'h0 ? 8'h1e : 8'h3e);
            7'h28: return v & (v[1:0] == 2'h3 ? 8'hc2 : 8'hc3);
            7'h29: return v & {1'b1, ~&v[7:6], 1'b1, ~&v[5:4], 4'h3};
            7'h2a: return v & (&v[7:6] ? 8'hbe : 8'hfe);
            default: return v;
        endcase
    endfunction

    // Walks every code of every field over the first twelve passes
    function automatic logic [7:0] pat(input logic [6:0] a, input logic [3:0] n);
        case (a)
            7'h26: return {2'h0, n[2:0], n[1:0], 1'b0};
            7'h28: return {n[1:0], 4'h0, n[1:0]};
            7'h29: return {n[1:0], n[1:0], 2'h0, n[1:0]};
            default: return {n, n[1:0], n[0], 1'b0};
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic r, input logic [6:0] a, input logic [7:0] v);
        @(negedge CLOCK);
        REG_WR = w;
        REG_RD = r;
        REG_ADDR = a;
        REG_WDATA = v;
        if (r)
            exp_q.push_back(sh[a]);
        if (w && (a == 7'h26 || (a >= 7'h28 && a <= 7'h2a)))
            sh[a] = a == 7'h26 ? v & 8'h3e : v;
        @(negedge CLOCK);
        REG_WR = 0;
        REG_RD = 0;
    endtask

    task automatic check_fields;
        check({2'h0, RIGHT_COMMON_DRIVER_CFG, SC_PROT_EN, SC_PROT_PDN_MODE,
            COMMON_MODE_LEVEL_SEL, SOFT_STEP_SEL, LEFT_DAC_ROUTE, RIGHT_DAC_ROUTE,
            WEAK_CM_BANDGAP}, {2'h0, sh[7'h26][5:2], sh[7'h26][1] & sh[7'h26][2],
            sh[7'h28][7:6], sh[7'h28][1:0], sh[7'h29][7:4], sh[7'h2a][1]});
    endtask

    task automatic do_reset;
        @(negedge CLOCK);
        RESET = 1;
        repeat (8) @(negedge CLOCK);
        for (int i = 0; i < 128; i++)
            sh[i] = 8'h00;
        check({LEFT_MUTE, LEFT_VOL_APPLIED, RIGHT_MUTE, RIGHT_VOL_APPLIED}, 16'h8080);
        check_fields;
        RESET = 0;
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge CLOCK);
            SAMPLE_TICK = 1;
            @(negedge CLOCK);
            SAMPLE_TICK = 0;
        end
        repeat (2) @(negedge CLOCK);
    endtask

    task automatic power(input logic [3:0] dc, input logic [1:0] sc, input int dly, input int stp);
        int n;
        bus(1, 0, 7'h2a, {dc, sc, 2'h0});
        @(negedge CLOCK);
        DRV_PWR_REQ = 1;
        n = 0;
        while (DRV_READY !== 1'b1 && n < 30000)
        begin
            @(negedge CLOCK);
            n++;
        end
        check(n[15:0], 16'(2 + dly + 7 * (stp + 1)));
        DRV_PWR_REQ = 0;
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Read results land one edge after the strobe and are judged against the oldest note
    always @(posedge CLOCK)
        rd_pend <= REG_RD && !RESET;
    always @(negedge CLOCK)
        if (rd_pend)
            check(16'(REG_RDATA), {8'h00, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx});

    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc > 50000)
        begin
            fails++;
            summarize;
        end
    end

    initial
    begin
        CLOCK = 0;
        forever
            #2 CLOCK = ~CLOCK;
    end

    initial
    begin
        {RESET, REG_WR, REG_RD, SAMPLE_TICK, DRV_PWR_REQ} = 5'h10;
        REG_ADDR = 7'h00;
        REG_WDATA = 8'h00;
        {LEFT_VOL_REG, RIGHT_VOL_REG} = 16'h0000;
        do_reset;
        for (int n = 0; n < 24; n++)
        begin
            foreach (rlist[j])
            begin
                d = n < 12 ? pat(rlist[j], n[3:0]) : rnd[7:0];
                rnd = lfsr(rnd);
                if (rlist[j] != 7'h27)
                    bus(1, 0, rlist[j], legal(rlist[j], d));
            end
            // Read and write together must return the old contents
            bus(1, 1, 7'h28, legal(7'h28, rnd[15:8]));
            @(negedge CLOCK);
            check_fields;
            foreach (rlist[j])
                bus(0, 1, rlist[j], 8'h00);
        end
        bus(1, 0, 7'h28, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            {LEFT_VOL_REG, RIGHT_VOL_REG} = rnd[15:0];
            rnd = lfsr(rnd);
            bus(1, 0, 7'h29, {6'h00, k[1:0]});
            repeat (3) @(negedge CLOCK);
            check({LEFT_MUTE, LEFT_VOL_APPLIED, RIGHT_MUTE, RIGHT_VOL_APPLIED},
                {k == 1 ? RIGHT_VOL_REG : LEFT_VOL_REG, k == 2 ? LEFT_VOL_REG : RIGHT_VOL_REG});
        end
        bus(1, 0, 7'h29, 8'h00);
        LEFT_VOL_REG = 8'h10;
        repeat (3) @(negedge CLOCK);
        for (int m = 0; m < 2; m++)
        begin
            bus(1, 0, 7'h28, {6'h00, m[1:0]});
            repeat (2) @(negedge CLOCK);
            LEFT_VOL_REG = LEFT_VOL_REG + 8'h08;
            ticks(4);
            check({9'h000, LEFT_VOL_APPLIED}, 16'h0014 + 16'(2 * m));
        end
        bus(1, 0, 7'h2a, 8'h0c);
        @(negedge CLOCK);
        DRV_PWR_REQ = 1;
        repeat (30) @(negedge CLOCK);
        DRV_PWR_REQ = 0;
        repeat (2) @(negedge CLOCK);
        check({12'h000, DRV_READY, DRV_RAMP_LEVEL}, 16'h0000);
        for (int c = 0; c < 12; c++)
            power(c[3:0], c[1:0], dtab[c], stab[c[1:0]]);
        do_reset;
        foreach (rlist[j])
            bus(0, 1, rlist[j], 8'h00);
        repeat (2) @(negedge CLOCK);
        check(16'(exp_q.size()), 16'h0000);
        summarize;
    end
endmodule // tb_top
`default_nettype wire
